// ---- core/sacp_core.sv ----
// Digital control of a serial sampling converter with nap and sleep
// Functional notes
// - Clamp above full scale to ones, below zero
// - Natural binary code, span two to resolution
// - Reset leaves block active, ready to convert
// - Two strobes without clock edge enter nap
// - Reference stays powered during nap
// - Clock edge wakes nap without restarting edge count; next strobe accepted once count reaches 16
// - Four strobes without clock edge enter sleep
// - Clock edge brings sleep back to active
// - Strobe starts; others ignored for 16 edges
// - Result fully shifted within first 16 periods
// - Only strobe rising edge matters
// - Sample captured at strobe rising edge
// - Three wires: clock, strobe, data out
// - Data from third edge, MSB first
// - Data output released when not sending
`timescale 1ns/10ps

module sacp_core #(
    parameter int RES_BITS = sacp_pkg::RES_WIDE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic convert_strobe,
    input wire logic signed [RES_BITS+1:0] sample_in,
    output logic sdo_o,
    output logic sdo_oe_n,
    output logic nap_o,
    output logic sleep_o,
    output logic ref_on_o,
    output logic adc_on_o,
    output logic convert_strobe_busy_o
);

    localparam logic [4:0] LAST_BIT_EDGE =
        5'(int'(sacp_pkg::FIRST_BIT_EDGE) + RES_BITS - 1);
    localparam logic [RES_BITS-1:0] CODE_MAX = '1;

    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic in_window(input logic [4:0] c);
        in_window = (c >= sacp_pkg::FIRST_BIT_EDGE) &&
                    (c <= LAST_BIT_EDGE);
    endfunction

    function automatic logic [RES_BITS-1:0] clamp_code(
        input logic signed [RES_BITS+1:0] s
    );
        logic signed [RES_BITS+1:0] top;
        top = $signed({2'b00, CODE_MAX});
        if (s < 0) begin
            clamp_code = '0;
        end else if (s > top) begin
            clamp_code = CODE_MAX;
        end else begin
            clamp_code = s[RES_BITS-1:0];
        end
    endfunction

    // ****************************************
    // Edge detection on the serial inputs
    // ****************************************
    logic sck_q;
    logic convert_strobe_q;
    logic sck_rise;
    logic convert_strobe_rise;

    assign sck_rise = sck && !sck_q;
    assign convert_strobe_rise = convert_strobe && !convert_strobe_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            sck_q <= 1'b0;
            convert_strobe_q <= 1'b0;
        end else begin
            sck_q <= sck;
            convert_strobe_q <= convert_strobe;
        end
    end

    // ****************************************
    // Frame edge counter
    // ****************************************
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [4:0] cnt_inc;
    logic busy;
    logic start;
    sacp_pkg::sacp_pwr_t pwr_q;
    sacp_pkg::sacp_pwr_t pwr_d;

    assign busy = cnt_q < sacp_pkg::FRAME_EDGES;
    assign start = convert_strobe_rise && !busy &&
                   (pwr_q == sacp_pkg::SACP_ACTIVE);
    assign cnt_inc = (cnt_q < sacp_pkg::CNT_SAT) ?
                     cnt_q + 5'h01 : cnt_q;
    assign cnt_d = start ? 5'h00 :
                   sck_rise ? cnt_inc : cnt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= sacp_pkg::CNT_RESET;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ****************************************
    // Sample hold and result shifting
    // ****************************************
    logic [RES_BITS-1:0] code_w;
    logic shift;
    logic oe_n_q;
    logic oe_n_d;

    assign code_w = clamp_code(sample_in);
    assign shift = sck_rise && !start && in_window(cnt_d);
    assign oe_n_d = !in_window(cnt_d);

    sacp_shreg #(
        .W(RES_BITS)
    ) u_shreg (
        .clk(clk),
        .rst(rst),
        .load(start),
        .load_word(code_w),
        .shift(shift),
        .bit_o(sdo_o)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= oe_n_d;
        end
    end

    assign sdo_oe_n = oe_n_q;

    // ****************************************
    // Power-down strobe counter
    // ****************************************
    logic [2:0] stb_q;
    logic [2:0] stb_d;
    logic [2:0] stb_inc;

    assign stb_inc = (stb_q < sacp_pkg::SLEEP_STROBES) ?
                     stb_q + 3'h1 : stb_q;
    assign stb_d = sck_rise ?
                   (convert_strobe_rise ? sacp_pkg::STB_ONE : 3'h0) :
                   convert_strobe_rise ? stb_inc : stb_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            stb_q <= sacp_pkg::STB_RESET;
        end else begin
            stb_q <= stb_d;
        end
    end

    // ****************************************
    // Power state machine
    // ****************************************
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            sacp_pkg::SACP_ACTIVE: begin
                if (stb_d == sacp_pkg::SLEEP_STROBES) begin
                    pwr_d = sacp_pkg::SACP_SLEEP;
                end else if (stb_d == sacp_pkg::NAP_STROBES) begin
                    pwr_d = sacp_pkg::SACP_NAP;
                end
            end
            sacp_pkg::SACP_NAP: begin
                if (sck_rise) begin
                    pwr_d = sacp_pkg::SACP_ACTIVE;
                end else if (stb_d == sacp_pkg::SLEEP_STROBES) begin
                    pwr_d = sacp_pkg::SACP_SLEEP;
                end
            end
            sacp_pkg::SACP_SLEEP: begin
                if (sck_rise) begin
                    pwr_d = sacp_pkg::SACP_ACTIVE;
                end
            end
            default: begin
                pwr_d = sacp_pkg::SACP_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_q <= sacp_pkg::SACP_ACTIVE;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    // ****************************************
    // Status outputs
    // ****************************************
    assign nap_o = pwr_q == sacp_pkg::SACP_NAP;
    assign sleep_o = pwr_q == sacp_pkg::SACP_SLEEP;
    assign ref_on_o = pwr_q != sacp_pkg::SACP_SLEEP;
    assign adc_on_o = pwr_q == sacp_pkg::SACP_ACTIVE;
    assign convert_strobe_busy_o = busy;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_accept;
        start;
    endsequence

    sequence s_third_edge;
        sck_rise && !start && cnt_q == 5'h02;
    endsequence

    sequence s_quiet_strobe(logic [2:0] n);
        convert_strobe_rise && !sck_rise && stb_q == n;
    endsequence

    clamp_high_a: assert property (
        s_accept ##0 (sample_in > $signed({2'b00, CODE_MAX}))
        |-> code_w == CODE_MAX)
        else $error("high input not clamped to ones");

    clamp_low_a: assert property (
        s_accept ##0 (sample_in < 0) |-> code_w == '0)
        else $error("negative input not clamped to zero");

    reset_active_a: assert property (
        $past(rst) |-> adc_on_o && sdo_oe_n && !busy)
        else $error("not active and idle after reset");

    nap_entry_a: assert property (
        adc_on_o ##0 s_quiet_strobe(3'h1) |=> nap_o)
        else $error("second quiet strobe did not nap");

    ref_in_nap_a: assert property (
        nap_o |-> ref_on_o && !adc_on_o && stb_q >= sacp_pkg::NAP_STROBES &&
                  stb_q < sacp_pkg::SLEEP_STROBES)
        else $error("reference off during nap");

    wake_up_a: assert property (
        sck_rise && !adc_on_o |=> adc_on_o ##0 stb_q <= 3'h1)
        else $error("clock edge did not wake");

    sleep_entry_a: assert property (
        s_quiet_strobe(3'h3) |=> sleep_o && !ref_on_o)
        else $error("fourth quiet strobe did not sleep");

    busy_ignore_a: assert property (
        s_accept |=> (!start) [*8])
        else $error("strobe accepted inside a frame");

    first_bit_a: assert property (
        s_third_edge ##0 adc_on_o |=> !sdo_oe_n)
        else $error("data not driven at third edge");

    release_a: assert property (
        !sdo_oe_n |-> cnt_q >= sacp_pkg::FIRST_BIT_EDGE &&
                      cnt_q <= sacp_pkg::FRAME_EDGES)
        else $error("data driven outside its window");

    strobe_clear_a: assert property (
        sck_rise && !convert_strobe_rise |=> stb_q == 3'h0)
        else $error("strobe count not cleared by clock");

endmodule

// ---- core/sacp_shreg.sv ----
// Result shift register, most significant bit out first
`timescale 1ns/10ps

module sacp_shreg #(
    parameter int W = 14
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] load_word,
    input wire logic shift,
    output logic bit_o
);

    logic [W-1:0] word_q;
    logic [W-1:0] word_d;
    logic bit_q;
    logic bit_d;

    // ****************************************
    // Next values
    // ****************************************
    assign word_d = load ? load_word :
                    shift ? {word_q[W-2:0], 1'b0} : word_q;
    assign bit_d = (shift && !load) ? word_q[W-1] : bit_q;
    assign bit_o = bit_q;

    // ****************************************
    // Storage
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            word_q <= '0;
            bit_q <= 1'b0;
        end else begin
            word_q <= word_d;
            bit_q <= bit_d;
        end
    end

endmodule

// ---- inc/sacp_pkg.sv ----
// Shared constants and types for the serial converter control block
package sacp_pkg;

    // ****************************************
    // Resolution options
    // ****************************************
    localparam int RES_WIDE = 14;
    localparam int RES_NARROW = 12;

    // ****************************************
    // Serial frame timing, in sck rising edges
    // ****************************************
    localparam int CNT_W = 5;
    localparam logic [4:0] FRAME_EDGES = 5'h10;
    localparam logic [4:0] FIRST_BIT_EDGE = 5'h03;
    localparam logic [4:0] CNT_SAT = 5'h11;
    localparam logic [4:0] CNT_RESET = 5'h11;

    // ****************************************
    // Power-down strobe counts
    // ****************************************
    localparam int STB_W = 3;
    localparam logic [2:0] STB_ONE = 3'h1;
    localparam logic [2:0] NAP_STROBES = 3'h2;
    localparam logic [2:0] SLEEP_STROBES = 3'h4;
    localparam logic [2:0] STB_RESET = 3'h0;

    // ****************************************
    // Power states
    // ****************************************
    typedef enum logic [1:0] {
        SACP_ACTIVE,
        SACP_NAP,
        SACP_SLEEP
    } sacp_pwr_t;

endpackage

// ---- tb/sacp_ctl_model.sv ----
// Controller model that drives the serial clock and strobe and gathers result bits
`timescale 1ns/10ps

module sacp_ctl_model #(
    parameter int SETTLE_CYC = 200
) (
    input wire logic clk,
    input wire logic sdo_o,
    input wire logic sdo_oe_n,
    output logic sck,
    output logic convert_strobe,
    output logic [15:0] rx_word,
    output logic [4:0] rx_cnt
);
    initial begin
        sck = 1'b0;
        convert_strobe = 1'b0;
        rx_word = 16'h0000;
        rx_cnt = 5'h00;
    end

    // ****************************************
    // Frame: n clock pulses, clock idles low outside
    // ****************************************
    task automatic frame(input int n, input bit with_strobe, input int extra);
        rx_word = 16'h0000;
        rx_cnt = 5'h00;
        if (with_strobe) begin
            @(posedge clk);
            #1 convert_strobe = 1'b1;
        end
        for (int i = 1; i <= n; i++) begin
            repeat (2) @(posedge clk);
            #1 sck = 1'b1;
            convert_strobe = (i == extra);
            repeat (2) @(posedge clk);
            #1;
            if (sdo_oe_n === 1'b0) begin
                rx_word = {rx_word[14:0], sdo_o};
                rx_cnt = rx_cnt + 5'h01;
            end
            sck = 1'b0;
        end
        convert_strobe = 1'b0;
    endtask

    // Strobe pulses with the clock held still
    task automatic strobes(input int k);
        repeat (k) begin
            @(posedge clk);
            #1 convert_strobe = 1'b1;
            repeat (2) @(posedge clk);
            #1 convert_strobe = 1'b0;
        end
    endtask

    // Shortened reference settling after sleep
    task automatic settle();
        repeat (SETTLE_CYC) @(posedge clk);
    endtask
endmodule

// ---- tb/serial_adc_convert_strobe_powerdown_tb.sv ----
// Self-checking bench for the serial converter control block
`timescale 1ns/10ps

module serial_adc_convert_strobe_powerdown_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sck, convert_strobe, sdo_o, sdo_oe_n;
    logic nap_o, sleep_o, ref_on_o, adc_on_o, convert_strobe_busy_o;
    logic signed [15:0] sample_in = 16'sh0000;
    logic signed [15:0] smp;
    logic [15:0] rx_word;
    logic [4:0] rx_cnt;
    logic [31:0] lfsr = 32'hEA54;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    logic signed [15:0] corners [6] = '{16'sh0000, 16'sh3FFF, 16'sh4000,
        16'shFFFF, 16'sh8000, 16'sh2AAA};

    always #5 clk = ~clk;

    sacp_core #(.RES_BITS(14)) u_dut (.clk(clk), .rst(rst), .sck(sck),
        .convert_strobe(convert_strobe), .sample_in(sample_in), .sdo_o(sdo_o),
        .sdo_oe_n(sdo_oe_n), .nap_o(nap_o), .sleep_o(sleep_o), .ref_on_o(ref_on_o),
        .adc_on_o(adc_on_o), .convert_strobe_busy_o(convert_strobe_busy_o));

    sacp_ctl_model u_ctl (.clk(clk), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .sck(sck),
        .convert_strobe(convert_strobe), .rx_word(rx_word), .rx_cnt(rx_cnt));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [15:0] exp_code(input logic signed [15:0] s);
        if (s < 16'sh0000) return 16'h0000;
        if (s > 16'sh3FFF) return 16'h3FFF;
        return {2'b00, s[13:0]};
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic run_frame(input logic signed [15:0] s, input int extra);
        sample_in = s;
        fork
            u_ctl.frame(18, 1'b1, extra);
            begin
                repeat (4) @(posedge clk);
                #1 sample_in = ~s;
                check("busy", {14'h0000, sdo_oe_n, convert_strobe_busy_o}, 16'h0003);
            end
        join
        check("data", rx_word, exp_code(s));
        check("bits", {11'h000, rx_cnt}, 16'h000E);
        check("idle", {14'h0000, sdo_oe_n, convert_strobe_busy_o}, 16'h0002);
    endtask

    task automatic check_pwr(input logic [3:0] exp);
        check("pwr", {12'h000, nap_o, sleep_o, ref_on_o, adc_on_o}, {12'h000, exp});
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            stop_test();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1;
        check("reset", {11'h000, sdo_oe_n, nap_o, sleep_o, ref_on_o, convert_strobe_busy_o},
            16'h0012);
        check_pwr(4'b0011);
        for (int i = 0; i < 14; i++) begin
            lfsr = lfsr_next(lfsr);
            smp = $signed(lfsr[15:0]) >>> lfsr[17:16];
            run_frame((i < 6) ? corners[i] : smp, (i % 2 == 1) ? 5 : 0);
        end
        u_ctl.strobes(3);
        check_pwr(4'b1010);
        u_ctl.strobes(1);
        check_pwr(4'b0100);
        u_ctl.frame(1, 1'b0, 0);
        check_pwr(4'b0011);
        u_ctl.frame(17, 1'b0, 0);
        u_ctl.settle();
        run_frame(16'sh1234, 0);
        u_ctl.strobes(2);
        check_pwr(4'b1010);
        u_ctl.frame(1, 1'b0, 0);
        check_pwr(4'b0011);
        u_ctl.frame(17, 1'b0, 0);
        run_frame(16'sh0FED, 3);
        stop_test();
    end
endmodule
